/* tpw_pkg.sv */
// constants, field layout and register map of the three channel pwm timer
// assumes a plain register port: address, write data, strobes, read data one cycle later
package tpw_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int DIV_W = 5;

    // register offsets
    localparam logic [8:0] OFS_MODE = 9'h120;
    localparam logic [8:0] OFS_CTRL1 = 9'h121;
    localparam logic [8:0] OFS_IOCFG = 9'h122;
    localparam logic [8:0] OFS_EXTCFG = 9'h123;
    localparam logic [8:0] OFS_CNT = 9'h126;
    localparam logic [8:0] OFS_GRA = 9'h128;
    localparam logic [8:0] OFS_GRB = 9'h12A;
    localparam logic [8:0] OFS_GRC = 9'h12C;
    localparam logic [8:0] OFS_GRD = 9'h12E;
    localparam logic [8:0] OFS_CTRL2 = 9'h130;
    localparam logic [8:0] OFS_PINSTAT = 9'h134;

    // timer mode register fields
    localparam int MODE_PWM_LSB = 0;
    localparam int MODE_BFC = 4;
    localparam int MODE_BFD = 5;
    localparam int MODE_START = 7;

    // control one fields
    localparam int CTRL1_TO_LSB = 0;
    localparam int CTRL1_TCK_LSB = 4;
    localparam int CTRL1_COUNTER_CLEAR_SELECT = 7;

    // control two fields
    localparam int CTRL2_POL_LSB = 0;
    localparam int CTRL2_STOP_ON_PERIOD_MATCH = 5;
    localparam logic [7:0] CTRL2_ONES = 8'h18;
    localparam logic [7:0] CTRL2_WMASK = 8'hE7;

    // io config: data in low nibble, direction in high nibble
    localparam int IOCFG_DATA_LSB = 0;
    localparam int IOCFG_DIR_LSB = 4;

    // interrupt pin config
    localparam int EXT_FN_LSB = 0;
    localparam logic [1:0] EXT_FN_IO = 2'h0;
    localparam logic [1:0] EXT_FN_IRQ = 2'h1;
    localparam logic [1:0] EXT_FN_CUTOFF = 2'h2;
    localparam int EXT_ADTRG_EN = 4;

    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h18;
    localparam logic [7:0] RST_IOCFG = 8'h00;
    localparam logic [7:0] RST_EXTCFG = 8'h00;
    localparam logic [15:0] RST_GR = 16'hFFFF;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // count source codes
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_DIV32 = 3'h4;
    localparam logic [2:0] SRC_EXTPIN = 3'h5;
    localparam logic [2:0] SRC_FAST_OSC = 3'h6;
    localparam logic [2:0] SRC_SEC_OSC = 3'h7;
endpackage

/* tpw_count_source.sv */
// count source selection: prescaler taps and synchronised edge detect of outside clocks
// assumes outside clocks are slower than half of mclk so every rising edge is seen
`timescale 1ns/1ps
module tpw_count_source
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // selection
    input wire logic [2:0] src_sel,
    // outside clock sources
    input wire logic external_count_clock_pin,
    input wire logic fast_onchip_osc_clock,
    input wire logic secondary_onchip_osc_clock,
    // one pulse per count event
    output logic count_tick
);
    logic [DIV_W-1:0] div_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    logic [2:0] rise;
    logic tick_next;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            div_reg <= '0;
        else
            div_reg <= div_reg + 5'h01;
    end

    // outside clocks are sampled as data: two flops, then a third for the edge
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {secondary_onchip_osc_clock, fast_onchip_osc_clock, external_count_clock_pin};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;

    always_comb
    begin
        unique case (src_sel)
            SRC_DIV1: tick_next = 1'b1;
            SRC_DIV2: tick_next = &div_reg[0:0];
            SRC_DIV4: tick_next = &div_reg[1:0];
            SRC_DIV8: tick_next = &div_reg[2:0];
            SRC_DIV32: tick_next = &div_reg[4:0];
            SRC_EXTPIN: tick_next = rise[0];
            SRC_FAST_OSC: tick_next = rise[1];
            SRC_SEC_OSC: tick_next = rise[2];
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            count_tick <= 1'b0;
        else
            count_tick <= tick_next;
    end
endmodule

/* tpw_timer.sv */
// pwm mode of a four channel compare timer: counter, compare, pins and register port
// assumes a plain single-cycle register master on mclk; pins are resolved outside
`timescale 1ns/1ps
module tpw_timer
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    // count sources
    input wire logic external_count_clock_pin,
    input wire logic fast_onchip_osc_clock,
    input wire logic secondary_onchip_osc_clock,
    // channel pins a to d, index 0 is a
    input wire logic [3:0] chan_pin_in,
    output logic [3:0] chan_pin_out,
    output logic [3:0] chan_pin_oe,
    // interrupt pin
    input wire logic external_interrupt_pin,
    // requests
    output logic [3:0] match_irq,
    output logic overflow_irq,
    output logic ext_irq_req,
    output logic adc_trigger
);
    // output level for a pwm pin from its active state and polarity
    function automatic logic pin_level(input logic active, input logic pol);
        pin_level = active ? pol : ~pol;
    endfunction

    // write decode used by every register
    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs, input logic w);
        wr_hit = w && (a == ofs);
    endfunction

    logic [7:0] timer_mode_reg;
    logic [7:0] timer_control_one_reg;
    logic [7:0] timer_control_two_reg;
    logic [7:0] io_config_reg;
    logic [7:0] ext_config_reg;
    logic [CNT_W-1:0] up_counter_reg;
    logic [CNT_W-1:0] period_compare_reg;
    logic [CNT_W-1:0] change_point_b_reg;
    logic [CNT_W-1:0] change_point_c_reg;
    logic [CNT_W-1:0] change_point_d_reg;
    logic [2:0] active_reg;
    logic [3:0] pin_sync1_reg;
    logic [3:0] pin_sync2_reg;
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;
    logic [DATA_W-1:0] read_next;
    logic count_tick;
    logic running;
    logic tick;
    logic match_a;
    logic period_stop;
    logic cutoff;
    logic [CNT_W-1:0] change_point [3];
    logic [2:0] cp_valid;

    assign running = timer_mode_reg[MODE_START];
    assign tick = count_tick && running;
    assign match_a = up_counter_reg == period_compare_reg;
    assign period_stop = tick && match_a && timer_control_two_reg[CTRL2_STOP_ON_PERIOD_MATCH];
    assign cutoff = (ext_config_reg[EXT_FN_LSB +: 2] == EXT_FN_CUTOFF) && !ext_sync2_reg;

    // channel b always uses register b; c and d lose their pin while buffering
    assign change_point[0] = change_point_b_reg;
    assign change_point[1] = change_point_c_reg;
    assign change_point[2] = change_point_d_reg;
    assign cp_valid = {~timer_mode_reg[MODE_BFD], ~timer_mode_reg[MODE_BFC], 1'b1};

    tpw_count_source u_src
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .src_sel(timer_control_one_reg[CTRL1_TCK_LSB +: 3]),
        .external_count_clock_pin(external_count_clock_pin),
        .fast_onchip_osc_clock(fast_onchip_osc_clock),
        .secondary_onchip_osc_clock(secondary_onchip_osc_clock),
        .count_tick(count_tick)
    );

    // pin inputs pass two flops before anything reads them
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_sync1_reg <= 4'h0;
            pin_sync2_reg <= 4'h0;
            ext_sync1_reg <= 1'b1;
            ext_sync2_reg <= 1'b1;
            ext_prev_reg <= 1'b1;
        end
        else
        begin
            pin_sync1_reg <= chan_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
            ext_sync1_reg <= external_interrupt_pin;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // mode register; the hardware stop only clears the start bit when software is not writing it
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timer_mode_reg <= RST_MODE;
        else if (wr_hit(addr, OFS_MODE, wr_en))
            timer_mode_reg <= wdata[7:0];
        else if (period_stop)
            timer_mode_reg[MODE_START] <= 1'b0;
    end

    // control one is taken as written; software keeps it still while counting
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timer_control_one_reg <= RST_CTRL1;
        else if (wr_hit(addr, OFS_CTRL1, wr_en))
            timer_control_one_reg <= wdata[7:0];
    end

    // bits three and four are tied to one; the edge field is stored but steers nothing here
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            timer_control_two_reg <= RST_CTRL2;
        else if (wr_hit(addr, OFS_CTRL2, wr_en))
            timer_control_two_reg <= (wdata[7:0] & CTRL2_WMASK) | CTRL2_ONES;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            io_config_reg <= RST_IOCFG;
            ext_config_reg <= RST_EXTCFG;
        end
        else
        begin
            if (wr_hit(addr, OFS_IOCFG, wr_en))
                io_config_reg <= wdata[7:0];
            if (wr_hit(addr, OFS_EXTCFG, wr_en))
                ext_config_reg <= wdata[7:0];
        end
    end

    // counter: a software load beats counting in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            up_counter_reg <= RST_CNT;
        else if (wr_hit(addr, OFS_CNT, wr_en))
            up_counter_reg <= wdata;
        else if (tick)
        begin
            if (match_a && timer_control_one_reg[CTRL1_COUNTER_CLEAR_SELECT])
                up_counter_reg <= RST_CNT;
            else
                up_counter_reg <= up_counter_reg + 16'h0001;
        end
    end

    // period and change points; buffered values move over at each period match
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            period_compare_reg <= RST_GR;
        else if (wr_hit(addr, OFS_GRA, wr_en))
            period_compare_reg <= wdata;
        else if (tick && match_a && timer_mode_reg[MODE_BFC])
            period_compare_reg <= change_point_c_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            change_point_b_reg <= RST_GR;
        else if (wr_hit(addr, OFS_GRB, wr_en))
            change_point_b_reg <= wdata;
        else if (tick && match_a && timer_mode_reg[MODE_BFD])
            change_point_b_reg <= change_point_d_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            change_point_c_reg <= RST_GR;
            change_point_d_reg <= RST_GR;
        end
        else
        begin
            if (wr_hit(addr, OFS_GRC, wr_en))
                change_point_c_reg <= wdata;
            if (wr_hit(addr, OFS_GRD, wr_en))
                change_point_d_reg <= wdata;
        end
    end

    // active state of pins b, c, d
    genvar j;
    generate
        for (j = 0; j < 3; j++)
        begin : g_chan
            logic equal_period;
            assign equal_period = change_point[j] == period_compare_reg;
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    active_reg[j] <= 1'b0;
                else if (wr_hit(addr, OFS_CTRL1, wr_en))
                    active_reg[j] <= wdata[CTRL1_TO_LSB + 1 + j];
                else if (tick && !equal_period)
                begin
                    if (cp_valid[j] && up_counter_reg == change_point[j])
                        active_reg[j] <= 1'b1;
                    else if (match_a)
                        active_reg[j] <= 1'b0;
                end
            end
        end
    endgenerate

    // pin drivers; pin a is only ever general io
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_pin
            logic pwm_sel;
            if (i == 0)
            begin : g_a
                assign pwm_sel = 1'b0;
            end
            else
            begin : g_bcd
                assign pwm_sel = timer_mode_reg[MODE_PWM_LSB + i - 1] && cp_valid[i - 1];
            end
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    chan_pin_out[i] <= 1'b0;
                    chan_pin_oe[i] <= 1'b0;
                end
                else if (pwm_sel)
                begin
                    // cutoff releases the pin rather than guessing a safe level
                    chan_pin_out[i] <= pin_level(active_reg[(i + 2) % 3],
                        timer_control_two_reg[CTRL2_POL_LSB + (i + 2) % 3]);
                    chan_pin_oe[i] <= !cutoff;
                end
                else
                begin
                    chan_pin_out[i] <= io_config_reg[IOCFG_DATA_LSB + i];
                    chan_pin_oe[i] <= io_config_reg[IOCFG_DIR_LSB + i];
                end
            end
        end
    endgenerate

    // request pulses, one clock each
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            match_irq <= 4'h0;
            overflow_irq <= 1'b0;
            adc_trigger <= 1'b0;
        end
        else
        begin
            match_irq[0] <= tick && match_a;
            match_irq[1] <= tick && up_counter_reg == change_point_b_reg;
            match_irq[2] <= tick && up_counter_reg == change_point_c_reg;
            match_irq[3] <= tick && up_counter_reg == change_point_d_reg;
            overflow_irq <= tick && up_counter_reg == CNT_MAX
                && !(match_a && timer_control_one_reg[CTRL1_COUNTER_CLEAR_SELECT]);
            adc_trigger <= tick && match_a && ext_config_reg[EXT_ADTRG_EN];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ext_irq_req <= 1'b0;
        else
            ext_irq_req <= (ext_config_reg[EXT_FN_LSB +: 2] == EXT_FN_IRQ)
                && ext_prev_reg && !ext_sync2_reg;
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        read_next = '0;
        unique case (addr)
            OFS_MODE: read_next[7:0] = timer_mode_reg;
            OFS_CTRL1: read_next[7:0] = timer_control_one_reg;
            OFS_CTRL2: read_next[7:0] = timer_control_two_reg;
            OFS_IOCFG: read_next[7:0] = io_config_reg;
            OFS_EXTCFG: read_next[7:0] = ext_config_reg;
            OFS_CNT: read_next = up_counter_reg;
            OFS_GRA: read_next = period_compare_reg;
            OFS_GRB: read_next = change_point_b_reg;
            OFS_GRC: read_next = change_point_c_reg;
            OFS_GRD: read_next = change_point_d_reg;
            OFS_PINSTAT: read_next[4:0] = {ext_sync2_reg, pin_sync2_reg};
            default: read_next = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (rd_en)
            rdata <= read_next;
        else
            rdata <= '0;
    end
endmodule

/* tpw_timer_assertions.sv */
// concurrent checks on the register port, request pulses and pin a of the pwm timer
// assumes only the top module ports are visible; attached by the bind at the foot
`timescale 1ns/1ps
module tpw_timer_checker
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    // pins and requests
    input wire logic [3:0] chan_pin_out,
    input wire logic [3:0] chan_pin_oe,
    input wire logic [3:0] match_irq,
    input wire logic overflow_irq,
    input wire logic ext_irq_req,
    input wire logic adc_trigger
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic iocfg_d1;
    logic iocfg_d2;
    // pin a may only move after software touched the io config, one or two cycles back
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            iocfg_d1 <= 1'b0;
            iocfg_d2 <= 1'b0;
        end
        else
        begin
            iocfg_d1 <= wr_en && (addr == OFS_IOCFG);
            iocfg_d2 <= iocfg_d1;
        end
    end
    property p_rdata_idle; !$past(rd_en) |-> rdata == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
    property p_unmapped; $past(rd_en) && $past(addr) == 9'h1F0 |-> rdata == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl2_ones; $past(rd_en) && $past(addr) == OFS_CTRL2 |-> rdata[4:3] == 2'h3; endproperty
    a_ctrl2_ones: assert property (p_ctrl2_ones) else $error("control two bits 3 and 4 not one");
    property p_ctrl2_rw;
        wr_en && addr == OFS_CTRL2 ##1 rd_en && addr == OFS_CTRL2
            |=> rdata[7:0] == (($past(wdata[7:0], 2) & CTRL2_WMASK) | CTRL2_ONES);
    endproperty
    a_ctrl2_rw: assert property (p_ctrl2_rw) else $error("control two readback wrong");
    property p_grb_rw; wr_en && addr == OFS_GRB ##1 rd_en && addr == OFS_GRB |=> rdata == $past(wdata, 2); endproperty
    a_grb_rw: assert property (p_grb_rw) else $error("change point b readback wrong");
    property p_adc_period; adc_trigger |-> match_irq[0]; endproperty
    a_adc_period: assert property (p_adc_period) else $error("adc trigger without period match");
    property p_ovf_pulse; overflow_irq |=> !overflow_irq; endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow request longer than one cycle");
    property p_ext_pulse; ext_irq_req |=> !ext_irq_req; endproperty
    a_ext_pulse: assert property (p_ext_pulse) else $error("interrupt pin request longer than one cycle");
    property p_pin_a_oe; $changed(chan_pin_oe[0]) |-> iocfg_d1 || iocfg_d2; endproperty
    a_pin_a_oe: assert property (p_pin_a_oe) else $error("pin a enable moved by the timer");
    property p_pin_a_out; $changed(chan_pin_out[0]) |-> iocfg_d1 || iocfg_d2; endproperty
    a_pin_a_out: assert property (p_pin_a_out) else $error("pin a level moved by the timer");
endmodule

bind tpw_timer tpw_timer_checker chk_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
    .match_irq(match_irq), .overflow_irq(overflow_irq), .ext_irq_req(ext_irq_req), .adc_trigger(adc_trigger));

/* three_channel_pwm_timer_tb_top.sv */
// self-checking bench for the pwm timer: registers, waveforms, count sources, stops, requests
// assumes the checker is bound from its own file; outside clocks are made here from mclk
`timescale 1ns/1ps
module three_channel_pwm_timer_tb_top;
    import tpw_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic ext_pin = 1'b0;
    logic fast_clk = 1'b0;
    logic sec_clk = 1'b0;
    logic int_pin = 1'b1;
    logic [15:0] rdata;
    logic [3:0] pin_out, pin_oe, pin_lvl, match;
    logic ovf, ext_req, adc;
    logic [15:0] v, c;
    logic [3:0] p;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_match[4], n_ovf, n_ext, n_adc, hi[4], gr[4];
    int dv[8] = '{1, 2, 4, 8, 32, 6, 4, 10};
    int m, pol, ini, lvl, lo, up;

    // released pins read back high, as with a pull-up
    assign pin_lvl = (pin_oe & pin_out) | ~pin_oe;
    tpw_timer dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .external_count_clock_pin(ext_pin), .fast_onchip_osc_clock(fast_clk),
        .secondary_onchip_osc_clock(sec_clk), .chan_pin_in(pin_lvl), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
        .external_interrupt_pin(int_pin), .match_irq(match), .overflow_irq(ovf), .ext_irq_req(ext_req),
        .adc_trigger(adc));

    initial
    begin
        forever #25 mclk = ~mclk;
    end

    // outside clocks of 6, 4 and 10 mclk periods; request pulses counted; hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        ext_pin <= (cyc % 6) < 3;
        fast_clk <= (cyc % 4) < 2;
        sec_clk <= (cyc % 10) < 5;
        if (rst_n)
        begin
            for (int i = 0; i < 4; i++) n_match[i] += (match[i] === 1'b1);
            n_ovf += (ovf === 1'b1);
            n_ext += (ext_req === 1'b1);
            n_adc += (adc === 1'b1);
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task give_verdict();
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task rd(input logic [8:0] a, output logic [15:0] q);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 q = rdata;
    endtask

    // write then read the same place with no gap
    task rw(input logic [8:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 q = rdata;
    endtask

    task clr_counts();
        for (int i = 0; i < 4; i++) n_match[i] = 0;
        n_ovf = 0;
        n_ext = 0;
        n_adc = 0;
    endtask

    initial
    begin
        void'($urandom(14));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_CTRL1, v);
        chk(v, 16'h0000);
        rd(OFS_CTRL2, v);
        chk(v, 16'h0018);
        rd(OFS_CNT, v);
        chk(v, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            c = 16'($urandom);
            rw(OFS_GRB, c, v);
            chk(v, c);
            rw(OFS_CTRL2, c, v);
            chk(v, (c & 16'h00E7) | 16'h0018);
            rw(OFS_CNT, c, v);
            chk(v, c);
            rw(9'h1F0, c, v);
            chk(v, 16'h0000);
        end
        // pin a as plain io, driven high
        wr(OFS_IOCFG, 16'h0011);
        repeat (3) @(posedge mclk);
        chk({14'h0, pin_oe[0], pin_out[0]}, 16'h0003);
        rd(OFS_PINSTAT, v);
        chk(v, 16'h001F);
        for (int t = 0; t < 4; t++)
        begin
            m = 4 + $urandom % 12;
            pol = $urandom % 8;
            ini = $urandom % 8;
            gr[1] = $urandom % m;
            gr[2] = (t == 1) ? m : $urandom % m;
            gr[3] = (t == 0) ? m : $urandom % m;
            wr(OFS_MODE, 16'h0000);
            wr(OFS_CNT, 16'h0000);
            wr(OFS_CTRL2, ($urandom & 16'h00C0) | pol);
            wr(OFS_GRA, m);
            wr(OFS_GRB, gr[1]);
            wr(OFS_GRC, gr[2]);
            wr(OFS_GRD, gr[3]);
            wr(OFS_MODE, 16'h0007);
            wr(OFS_CTRL1, 16'h0080 | (ini << 1));
            repeat (3) @(posedge mclk);
            #1;
            for (int ch = 1; ch < 4; ch++)
                chk(pin_out[ch], ini[ch-1] ? pol[ch-1] : !pol[ch-1]);
            wr(OFS_MODE, 16'h0087);
            repeat (2 * m + 8) @(posedge mclk);
            for (int ch = 1; ch < 4; ch++) hi[ch] = 0;
            repeat (m + 1)
            begin
                @(posedge mclk);
                #1;
                for (int ch = 1; ch < 4; ch++) hi[ch] += pin_out[ch];
            end
            for (int ch = 1; ch < 4; ch++)
            begin
                lvl = ini[ch-1] ? pol[ch-1] : !pol[ch-1];
                if (gr[ch] == m)
                    chk(hi[ch], lvl ? m + 1 : 0);
                else
                begin
                    up = pol[ch-1] ? m - gr[ch] : gr[ch] + 1;
                    chk(hi[ch], up);
                end
            end
            wr(OFS_MODE, 16'h0007);
            rd(OFS_CNT, c);
            p = pin_out;
            repeat (20) @(posedge mclk);
            chk(pin_out, p);
            rd(OFS_CNT, v);
            chk(v, c);
        end
        // every count source, free running for a fixed span
        for (int s = 0; s < 8; s++)
        begin
            wr(OFS_MODE, 16'h0000);
            wr(OFS_CNT, 16'h0000);
            wr(OFS_CTRL1, s << 4);
            wr(OFS_MODE, 16'h0080);
            repeat (320) @(posedge mclk);
            wr(OFS_MODE, 16'h0000);
            rd(OFS_CNT, v);
            lo = (320 - 12) / dv[s] - 1;
            up = (320 + 8) / dv[s] + 1;
            chk(16'(int'(v) >= lo && int'(v) <= up), 16'h0001);
        end
        // stop at the period match
        wr(OFS_CNT, 16'h0000);
        wr(OFS_GRA, 16'h0014);
        wr(OFS_CTRL2, 16'h0020);
        wr(OFS_CTRL1, 16'h0080);
        wr(OFS_MODE, 16'h0081);
        repeat (40) @(posedge mclk);
        rd(OFS_MODE, v);
        chk(v & 16'h0080, 16'h0000);
        rd(OFS_CNT, v);
        chk(v, 16'h0000);
        // compare and overflow requests across the wrap
        wr(OFS_CTRL2, 16'h0000);
        wr(OFS_CTRL1, 16'h0000);
        wr(OFS_GRA, 16'h0010);
        wr(OFS_GRB, 16'h0003);
        wr(OFS_GRC, 16'hFFF8);
        wr(OFS_GRD, 16'h0008);
        wr(OFS_EXTCFG, 16'h0010);
        wr(OFS_CNT, 16'hFFF0);
        clr_counts();
        wr(OFS_MODE, 16'h0080);
        repeat (40) @(posedge mclk);
        wr(OFS_MODE, 16'h0000);
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 4; i++) chk(n_match[i], 1);
        chk(n_ovf, 1);
        chk(n_adc, 1);
        // interrupt pin as request input, one falling edge
        wr(OFS_EXTCFG, {14'h0, EXT_FN_IRQ});
        @(posedge mclk);
        int_pin <= 1'b0;
        repeat (10) @(posedge mclk);
        int_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(n_ext, 1);
        // buffers carry next period and next change point b
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CTRL1, 16'h0080);
        wr(OFS_GRA, 16'h000A);
        wr(OFS_GRB, 16'h0003);
        wr(OFS_GRC, 16'h0007);
        wr(OFS_GRD, 16'h0002);
        wr(OFS_EXTCFG, {14'h0, EXT_FN_CUTOFF});
        wr(OFS_MODE, 16'h00B1);
        repeat (4) @(posedge mclk);
        chk(pin_oe, 4'h3);
        int_pin <= 1'b0;
        repeat (13) @(posedge mclk);
        chk(pin_oe, 4'h1);
        int_pin <= 1'b1;
        repeat (13) @(posedge mclk);
        wr(OFS_MODE, 16'h0000);
        rd(OFS_GRA, v);
        chk(v, 16'h0007);
        rd(OFS_GRB, v);
        chk(v, 16'h0002);
        give_verdict();
    end
endmodule
